/* File: rtl/cstg_consts.vh */
// register offsets, field positions, reset values and serial frame sizes for the control block
`ifndef CSTG_CONSTS_VH
`define CSTG_CONSTS_VH

// ----------------------------------------------------------------
// register offsets on the serial port (13-bit address space)
// ----------------------------------------------------------------
`define CSTG_ADDR_W 13
`define CSTG_OFS_GPO 13'h000E
`define CSTG_OFS_PROF_TRIG 13'h010C
`define CSTG_OFS_CHIP_SEL 13'h0115
`define CSTG_OFS_TONE 13'h0116

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CSTG_PROF_IDX_MSB 4
`define CSTG_SOFT_TRIG_BIT 5
`define CSTG_CHIP_ID_MSB 4
`define CSTG_CHIP_MODE_BIT 5
`define CSTG_TONE_EN_BIT 0
`define CSTG_TONE_LVL_LSB 2
`define CSTG_TONE_LVL_MSB 3
`define CSTG_TONE_LVL_RSVD 2'h3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CSTG_RST_GPO 4'h0
`define CSTG_RST_PROF 5'h00
`define CSTG_RST_CHIP 6'h00
`define CSTG_RST_TONE_LVL 2'h0

// ----------------------------------------------------------------
// serial frame: 16-bit instruction then one data byte
// ----------------------------------------------------------------
`define CSTG_INSTR_BITS 5'h10
`define CSTG_FRAME_BITS 5'h18
`define CSTG_RW_BIT 15

`endif

/* File: rtl/cstg_ctrl.v */
// serial register port with chip select, trigger merge, general outputs and test tone control
`timescale 1ns/1ps
`default_nettype none
`include "cstg_consts.vh"
module cstg_ctrl (
  // clock and reset
  input wire clk_i,
  input wire nrst_i,
  // serial register port (three-wire, data pin is two-way)
  input wire sclk_i,
  input wire csb_n_i,
  input wire sdio_i,
  output reg sdio_o,
  output reg sdio_oe_o,
  // strapped chip id pins and hardware trigger
  input wire [4:0] strap_id_pin_i,
  input wire transmit_sync_input_i,
  // general output pins
  output reg general_output_pin_0_o,
  output reg general_output_pin_1_o,
  output reg general_output_pin_2_o,
  output reg general_output_pin_3_o,
  // trigger actions, one-cycle pulses
  output reg demod_reset_o,
  output reg power_seq_start_o,
  output reg framer_align_o,
  // profile load request
  output reg profile_load_o,
  output reg [4:0] profile_index_o,
  // analog test tone control
  output reg tone_enable_o,
  output reg [1:0] tone_level_o
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  wire sclk_s; // serial clock, sampled
  wire csb_n_s; // chip select, sampled
  wire sdio_s; // serial data in, sampled
  wire trig_s; // hardware trigger, sampled
  wire [4:0] strap_s; // strap pins, sampled

  // reset loads 4'h2, so sampled data in starts high and sampled csb starts low
  cstg_sync #(.W(4), .INIT(4'h2)) u_sync_spi (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .async_i({sclk_i, csb_n_i, sdio_i, transmit_sync_input_i}),
    .sync_o({sclk_s, csb_n_s, sdio_s, trig_s})
  );

  cstg_sync #(.W(5), .INIT(5'h00)) u_sync_strap (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .async_i(strap_id_pin_i),
    .sync_o(strap_s)
  );

  // ----------------------------------------------------------------
  // serial clock and trigger edge detection
  // ----------------------------------------------------------------
  reg sclk_d_r; // previous sampled serial clock
  reg trig_d_r; // previous sampled trigger
  wire sclk_rise = sclk_s & ~sclk_d_r;
  wire sclk_fall = ~sclk_s & sclk_d_r;
  wire hw_trig = trig_s & ~trig_d_r; // rising edge of trigger pin

  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sclk_d_r <= 1'b0;
      trig_d_r <= 1'b0;
    end else begin
      sclk_d_r <= sclk_s;
      trig_d_r <= trig_s;
    end
  end

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  reg [3:0] gpo_r; // general output levels
  reg [4:0] prof_r; // profile index
  reg [5:0] chip_r; // chip select mode and id
  reg tone_en_r; // tone routed to amplifier inputs
  reg [1:0] tone_lvl_r; // tone amplitude code

  // ----------------------------------------------------------------
  // serial frame state
  // ----------------------------------------------------------------
  reg [4:0] bit_cnt_r; // bits received in this frame
  reg [15:0] instr_r; // instruction word
  reg [7:0] data_r; // data shift register
  reg [7:0] rd_sh_r; // read data shifting out
  reg rd_act_r; // read data phase active

  wire [`CSTG_ADDR_W-1:0] addr = instr_r[`CSTG_ADDR_W-1:0];
  wire is_read = instr_r[`CSTG_RW_BIT];

  // chip select filter: the select register itself stays reachable
  // so a deselected device can always be re-addressed
  wire mode_on = chip_r[`CSTG_CHIP_MODE_BIT];
  wire id_match = (chip_r[`CSTG_CHIP_ID_MSB:0] == strap_s);
  wire selected = ~mode_on | id_match;
  wire addr_global = (addr == `CSTG_OFS_CHIP_SEL);
  wire access_ok = selected | addr_global;

  // write fires as the last data bit is sampled
  wire last_bit = sclk_rise & ~csb_n_s & (bit_cnt_r == `CSTG_FRAME_BITS - 5'h01);
  wire wr_fire = last_bit & ~is_read & access_ok;
  wire [7:0] wdata = {data_r[6:0], sdio_s};
  wire prof_wr = wr_fire & (addr == `CSTG_OFS_PROF_TRIG);
  wire soft_trig = prof_wr & wdata[`CSTG_SOFT_TRIG_BIT];
  wire trig_evt = hw_trig | soft_trig;

  // ------------------------------------------------
  // read data mux; unmapped and reserved bits read zero
  // ------------------------------------------------
  reg [7:0] rdata;
  always @* begin
    rdata = 8'h00;
    case (addr)
      `CSTG_OFS_GPO: rdata = {4'h0, gpo_r};
      `CSTG_OFS_PROF_TRIG: rdata = {3'h0, prof_r}; // trigger bit reads zero
      `CSTG_OFS_CHIP_SEL: rdata = {2'h0, chip_r};
      `CSTG_OFS_TONE: rdata = {4'h0, tone_lvl_r, 1'b0, tone_en_r};
      default: rdata = 8'h00;
    endcase
  end

  // ------------------------------------------------
  // frame receiver: counts and shifts on serial clock rises
  // ------------------------------------------------
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bit_cnt_r <= 5'h00;
      instr_r <= 16'h0000;
      data_r <= 8'h00;
    end else if (csb_n_s) begin
      bit_cnt_r <= 5'h00; // frame ends, bits beyond a byte are dropped
    end else if (sclk_rise) begin
      if (bit_cnt_r < `CSTG_INSTR_BITS)
        instr_r <= {instr_r[14:0], sdio_s};
      else
        data_r <= wdata;
      if (bit_cnt_r != `CSTG_FRAME_BITS)
        bit_cnt_r <= bit_cnt_r + 5'h01;
    end
  end

  // ------------------------------------------------
  // read driver: data changes on serial clock falls
  // ------------------------------------------------
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_act_r <= 1'b0;
      rd_sh_r <= 8'h00;
      sdio_o <= 1'b0;
      sdio_oe_o <= 1'b0;
    end else if (csb_n_s) begin
      rd_act_r <= 1'b0;
      sdio_oe_o <= 1'b0;
    end else if (sclk_fall) begin
      if (bit_cnt_r == `CSTG_INSTR_BITS && is_read && access_ok) begin
        // a deselected device keeps the data pin released unless the chip select register is read
        rd_act_r <= 1'b1;
        sdio_oe_o <= 1'b1;
        sdio_o <= rdata[7];
        rd_sh_r <= {rdata[6:0], 1'b0};
      end else if (rd_act_r && bit_cnt_r < `CSTG_FRAME_BITS) begin
        sdio_o <= rd_sh_r[7];
        rd_sh_r <= {rd_sh_r[6:0], 1'b0};
      end else begin
        rd_act_r <= 1'b0;
        sdio_oe_o <= 1'b0;
      end
    end
  end

  // ------------------------------------------------
  // register writes
  // ------------------------------------------------
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      gpo_r <= `CSTG_RST_GPO;
      prof_r <= `CSTG_RST_PROF;
      chip_r <= `CSTG_RST_CHIP;
      tone_en_r <= 1'b0;
      tone_lvl_r <= `CSTG_RST_TONE_LVL;
    end else if (wr_fire) begin
      case (addr)
        `CSTG_OFS_GPO: gpo_r <= wdata[3:0];
        `CSTG_OFS_PROF_TRIG: prof_r <= wdata[`CSTG_PROF_IDX_MSB:0];
        `CSTG_OFS_CHIP_SEL: chip_r <= wdata[5:0];
        `CSTG_OFS_TONE: begin
          tone_en_r <= wdata[`CSTG_TONE_EN_BIT];
          // the reserved code is refused so the tone never sees it
          if (wdata[`CSTG_TONE_LVL_MSB:`CSTG_TONE_LVL_LSB] != `CSTG_TONE_LVL_RSVD)
            tone_lvl_r <= wdata[`CSTG_TONE_LVL_MSB:`CSTG_TONE_LVL_LSB];
        end
        default: tone_en_r <= tone_en_r;
      endcase
    end
  end

  // ------------------------------------------------
  // outputs: levels from registers, trigger actions as pulses
  // ------------------------------------------------
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      general_output_pin_0_o <= 1'b0;
      general_output_pin_1_o <= 1'b0;
      general_output_pin_2_o <= 1'b0;
      general_output_pin_3_o <= 1'b0;
      demod_reset_o <= 1'b0;
      power_seq_start_o <= 1'b0;
      framer_align_o <= 1'b0;
      profile_load_o <= 1'b0;
      profile_index_o <= `CSTG_RST_PROF;
      tone_enable_o <= 1'b0;
      tone_level_o <= `CSTG_RST_TONE_LVL;
    end else begin
      general_output_pin_0_o <= gpo_r[0];
      general_output_pin_1_o <= gpo_r[1];
      general_output_pin_2_o <= gpo_r[2];
      general_output_pin_3_o <= gpo_r[3];
      // soft trigger exists only in the write cycle, so it cannot repeat
      demod_reset_o <= trig_evt;
      power_seq_start_o <= trig_evt;
      framer_align_o <= trig_evt;
      profile_load_o <= prof_wr;
      // the load pulse must carry the index it loads, not the one before it
      profile_index_o <= prof_wr ? wdata[`CSTG_PROF_IDX_MSB:0] : prof_r;
      tone_enable_o <= tone_en_r;
      tone_level_o <= tone_lvl_r;
    end
  end

endmodule // cstg_ctrl
`default_nettype wire

/* File: rtl/cstg_sync.v */
// two flip-flop synchroniser for signals arriving from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module cstg_sync #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  // clock and reset
  input wire clk_i,
  input wire nrst_i,
  // asynchronous input and its synchronised copy
  input wire [W-1:0] async_i,
  output reg [W-1:0] sync_o
);

  reg [W-1:0] meta_r; // first stage, read only by the second stage

  // ------------------------------------------------
  // two stages; only sync_o may be used by logic
  // ------------------------------------------------
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_r <= INIT;
      sync_o <= INIT;
    end else begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end

endmodule // cstg_sync
`default_nettype wire

/* File: test/cstg_ctrl_chk.sv */
// port checker for the control block, bound to its top
`timescale 1ns/1ps
`default_nettype none
module cstg_ctrl_chk (
  // clock, reset and input pins
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic csb_n_i,
  input wire logic transmit_sync_input_i,
  // level and pulse outputs
  input wire logic general_output_pin_0_o,
  input wire logic general_output_pin_1_o,
  input wire logic general_output_pin_2_o,
  input wire logic general_output_pin_3_o,
  input wire logic demod_reset_o,
  input wire logic power_seq_start_o,
  input wire logic framer_align_o,
  input wire logic profile_load_o,
  input wire logic tone_enable_o,
  input wire logic [4:0] profile_index_o,
  input wire logic [1:0] tone_level_o
);
  // ----------------------------------------
  // one clock domain, so shared defaults
  // ----------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // pins gathered so one check covers all four
  wire logic [3:0] gpo = {general_output_pin_3_o, general_output_pin_2_o,
    general_output_pin_1_o, general_output_pin_0_o};
  property p_gpo; !$stable(gpo) |-> !csb_n_i; endproperty
  a_gpo: assert property (p_gpo) else $error("pins moved outside a frame");
  property p_tone; !$stable({tone_enable_o, tone_level_o}) |-> !csb_n_i; endproperty
  a_tone: assert property (p_tone) else $error("tone moved outside a frame");
  property p_rsvd; tone_level_o != 2'h3; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved tone level");
  property p_hw; $rose(transmit_sync_input_i) |-> ##[2:5] demod_reset_o; endproperty
  a_hw: assert property (p_hw) else $error("pin edge gave no pulse");
  property p_trio; demod_reset_o |-> power_seq_start_o && framer_align_o; endproperty
  a_trio: assert property (p_trio) else $error("pulses apart");
  property p_one; demod_reset_o |=> !demod_reset_o; endproperty
  a_one: assert property (p_one) else $error("pulse too long");
  property p_idx; !$stable(profile_index_o) |-> profile_load_o; endproperty
  a_idx: assert property (p_idx) else $error("index moved without load");
  property p_load; profile_load_o |-> !csb_n_i; endproperty
  a_load: assert property (p_load) else $error("load outside a frame");
endmodule // cstg_ctrl_chk
bind cstg_ctrl cstg_ctrl_chk i_cstg_ctrl_chk (.clk_i(clk_i), .nrst_i(nrst_i),
  .csb_n_i(csb_n_i), .transmit_sync_input_i(transmit_sync_input_i),
  .general_output_pin_0_o(general_output_pin_0_o), .general_output_pin_1_o(general_output_pin_1_o),
  .general_output_pin_2_o(general_output_pin_2_o), .general_output_pin_3_o(general_output_pin_3_o),
  .demod_reset_o(demod_reset_o), .power_seq_start_o(power_seq_start_o),
  .framer_align_o(framer_align_o), .profile_load_o(profile_load_o),
  .tone_enable_o(tone_enable_o), .profile_index_o(profile_index_o), .tone_level_o(tone_level_o));
`default_nettype wire

/* File: test/cstg_ctrl_tb.sv */
// self-checking bench for the control block
`timescale 1ns/1ps
`default_nettype none
`include "cstg_consts.vh"
module cstg_ctrl_tb;
  // ----------------------------------------
  // clock, pins and bookkeeping
  // ----------------------------------------
  logic clk_i = 1'b0, nrst_i = 1'b0, trg = 1'b0;
  logic [4:0] strap = 5'h00;
  wire logic sclk, csb_n, h_d, h_oe, d_d, d_oe, sdio, dr, ps, fa, pl, te;
  wire logic [3:0] gpo;
  wire logic [4:0] pidx;
  wire logic [1:0] tl;
  int fails = 0, checks = 0, seed = 26688;
  logic [7:0] rq[$], rv, v, s, junk;
  logic [3:0] tq[$];
  logic [1:0] lv;
  event got;
  always #5 clk_i = ~clk_i;
  // a released data line falls to its pull-down level
  assign sdio = h_oe ? h_d : (d_oe ? d_d : 1'b0);
  cstg_host i_cstg_host (.sdio_i(sdio), .sclk_o(sclk), .csb_n_o(csb_n), .sdio_o(h_d),
    .sdio_oe_o(h_oe));
  cstg_ctrl i_cstg_ctrl (.clk_i(clk_i), .nrst_i(nrst_i), .sclk_i(sclk), .csb_n_i(csb_n),
    .sdio_i(sdio), .sdio_o(d_d), .sdio_oe_o(d_oe), .strap_id_pin_i(strap),
    .transmit_sync_input_i(trg), .general_output_pin_0_o(gpo[0]),
    .general_output_pin_1_o(gpo[1]), .general_output_pin_2_o(gpo[2]),
    .general_output_pin_3_o(gpo[3]), .demod_reset_o(dr), .power_seq_start_o(ps),
    .framer_align_o(fa), .profile_load_o(pl), .profile_index_o(pidx), .tone_enable_o(te),
    .tone_level_o(tl));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    @(negedge clk_i);
    i_cstg_host.xfer(1'b0, a, d, junk);
  endtask
  // the note goes in first, the monitor compares when the byte lands
  task automatic rd(input logic [12:0] a, input logic [7:0] e);
    rq.push_back(e);
    @(negedge clk_i);
    i_cstg_host.xfer(1'b1, a, 8'h00, rv);
    ->got;
  endtask
  task automatic stop_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // monitors: read bytes, and trigger pulses against their notes
  always @(got) cmp(rv, rq.pop_front());
  // looked at mid-cycle, where a pulse launched at the rising edge has settled
  always @(negedge clk_i) if ((dr | ps | fa | pl) !== 1'b0)
    cmp({4'h0, dr, ps, fa, pl}, tq.size() ? {4'h0, tq.pop_front()} : 8'hFF);
  // watchdog, well past the expected run of about 11k cycles
  initial begin
    #300000;
    fails++;
    $display("unexpected at %0t: watchdog expired", $time);
    stop_test;
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(negedge clk_i);
    nrst_i = 1'b1;
    repeat (4) @(negedge clk_i);
    rd(`CSTG_OFS_GPO, 8'h00);
    rd(`CSTG_OFS_PROF_TRIG, 8'h00);
    rd(`CSTG_OFS_CHIP_SEL, 8'h00);
    wr(13'h0001, 8'hFF);
    rd(13'h0001, 8'h00);
    $display("test reset done");
    repeat (4) begin
      v = $random(seed);
      wr(`CSTG_OFS_GPO, v);
      cmp({4'h0, gpo}, {4'h0, v[3:0]});
      rd(`CSTG_OFS_GPO, {4'h0, v[3:0]});
    end
    lv = 2'h0;
    for (int c = 0; c < 4; c++) begin
      wr(`CSTG_OFS_TONE, {4'h0, c[1:0], 1'b0, c[0]});
      if (c != 3) lv = c[1:0];
      cmp({5'h00, te, tl}, {5'h00, c[0], lv});
      rd(`CSTG_OFS_TONE, {4'h0, lv, 1'b0, c[0]});
    end
    $display("test outputs done");
    v = $random(seed) & 8'h1F;
    tq.push_back(4'h1);
    wr(`CSTG_OFS_PROF_TRIG, v);
    cmp({3'h0, pidx}, v);
    tq.push_back(4'hF);
    wr(`CSTG_OFS_PROF_TRIG, v | 8'h20);
    rd(`CSTG_OFS_PROF_TRIG, v);
    repeat (2) begin
      tq.push_back(4'hE);
      trg = 1'b1;
      repeat (8 + ($random(seed) & 7)) @(negedge clk_i);
      trg = 1'b0;
      repeat (8) @(negedge clk_i);
    end
    cmp(8'(tq.size()), 8'h00);
    $display("test trigger done");
    s = $random(seed) & 8'h1F;
    @(negedge clk_i);
    strap = s[4:0];
    wr(`CSTG_OFS_GPO, 8'h05);
    cmp({4'h0, gpo}, 8'h05);
    wr(`CSTG_OFS_CHIP_SEL, (s ^ 8'h01) | 8'h20);
    wr(`CSTG_OFS_GPO, 8'h0A);
    wr(`CSTG_OFS_PROF_TRIG, 8'h20);
    cmp({4'h0, gpo}, 8'h05);
    rd(`CSTG_OFS_GPO, 8'h00);
    rd(`CSTG_OFS_CHIP_SEL, (s ^ 8'h01) | 8'h20);
    wr(`CSTG_OFS_CHIP_SEL, s | 8'h20);
    wr(`CSTG_OFS_GPO, 8'h0A);
    cmp({4'h0, gpo}, 8'h0A);
    wr(`CSTG_OFS_CHIP_SEL, s ^ 8'h03);
    wr(`CSTG_OFS_GPO, 8'h06);
    cmp({4'h0, gpo}, 8'h06);
    $display("test chip select done");
    // a second reset in mid-run must bring back the output pins, chip select and tone registers
    @(negedge clk_i);
    nrst_i = 1'b0;
    repeat (3) @(negedge clk_i);
    cmp({4'h0, gpo}, 8'h00);
    nrst_i = 1'b1;
    repeat (4) @(negedge clk_i);
    rd(`CSTG_OFS_CHIP_SEL, 8'h00);
    rd(`CSTG_OFS_TONE, 8'h00);
    $display("test mid reset done");
    stop_test;
  end
endmodule // cstg_ctrl_tb
`default_nettype wire

/* File: test/cstg_host.sv */
// host model: drives single-byte serial frames at the link rate
`timescale 1ns/1ps
`default_nettype none
module cstg_host (
  // shared data line as seen on the board
  input wire logic sdio_i,
  // host pins
  output logic sclk_o,
  output logic csb_n_o,
  output logic sdio_o,
  output logic sdio_oe_o
);
  // idle: clock parked low, select released high
  initial begin
    sclk_o = 1'b0;
    csb_n_o = 1'b1;
    sdio_o = 1'b0;
    sdio_oe_o = 1'b0;
  end
  // one frame, msb first; data changes while the clock is low
  task automatic xfer(input logic rd, input logic [12:0] adr, input logic [7:0] wd,
    output logic [7:0] rdat);
    logic [23:0] f;
    // start just past a falling clock edge so no pin ever moves on a rising one
    #1.25;
    f = {rd, 2'b00, adr, wd};
    csb_n_o = 1'b0;
    sdio_oe_o = 1'b1;
    for (int i = 23; i >= 0; i--) begin
      // release the line so the device can answer a read
      if (rd && i < 8) sdio_oe_o = 1'b0;
      sdio_o = f[i];
      #62.5 sclk_o = 1'b1;
      rdat[i % 8] = sdio_i;
      #62.5 sclk_o = 1'b0;
    end
    sdio_oe_o = 1'b0;
    #62.5 csb_n_o = 1'b1;
    #62.5;
  endtask
endmodule // cstg_host
`default_nettype wire
